// ==== rtl/acm_pkg.sv ====
// Constants, types and register map of the converter control block.
package acm_pkg;
  // ****************************************
  // Data path
  // ****************************************
  localparam int          DW        = 12;
  localparam logic [11:0] CODE_MIN  = 12'h000;
  localparam logic [11:0] CODE_MAX  = 12'hfff;
  localparam int          GAIN_W    = 15;
  localparam int          OFS_W     = 13;
  localparam int          GAIN_SH   = 14;
  localparam logic [14:0] GAIN_RST  = 15'h4000;
  localparam logic [12:0] OFS_RST   = 13'h0000;
  localparam int          OFS_SIGN  = 12;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0]  REG_CFG    = 8'h00;
  localparam logic [7:0]  REG_GAIN_I = 8'h04;
  localparam logic [7:0]  REG_GAIN_Q = 8'h08;
  localparam logic [7:0]  REG_OFS_I  = 8'h0c;
  localparam logic [7:0]  REG_OFS_Q  = 8'h10;
  localparam logic [7:0]  REG_STATUS = 8'h14;
  localparam logic [15:0] CFG_RST    = 16'h0000;
  localparam int          CFG_CAL    = 15;
  localparam int          CFG_PHASE  = 14;
  localparam int          CFG_DES    = 7;
  localparam int          CFG_DEQ    = 6;
  localparam int          CFG_BOTH   = 5;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
  localparam logic        HRESP_OKAY    = 1'b0;

  // ****************************************
  // Synchronised pin indices
  // ****************************************
  localparam int PIN_N     = 9;
  localparam int P_MODE_N  = 0;
  localparam int P_DES     = 1;
  localparam int P_NODEMUX = 2;
  localparam int P_PHASE   = 3;
  localparam int P_CAL     = 4;
  localparam int P_WAIT    = 5;
  localparam int P_PD_I    = 6;
  localparam int P_PD_Q    = 7;
  localparam int P_PATTERN = 8;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_NS       = 10;
  localparam logic [15:0] CAL_LOW_MIN  = 16'd1280;
  localparam logic [15:0] CAL_HIGH_MIN = 16'd1280;
  localparam logic [23:0] STRAP_CYC    = 24'd4;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {SEL_I, SEL_Q, SEL_BOTH} acm_insel_t;
  typedef struct packed {
    logic [11:0] code;
    logic        under;
    logic        over;
  } acm_conv_t;
  typedef struct packed {
    logic       serial;
    logic       des;
    logic       demux;
    logic       phase;
    logic       pattern;
    acm_insel_t inSel;
  } acm_mode_t;
endpackage

// ==== rtl/acm_sync.sv ====
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
module acm_sync
  import acm_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst,
  // Pins in, settled levels out.
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // The first stage feeds only the second, keeping metastability out of logic.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      pinOut <= '0;
    end
    else
    begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pinOut <= (s2_r & s3_r) | (pinOut & (s2_r | s3_r)); // Change only on agreement.
    end
  end
endmodule // acm_sync

// ==== rtl/acm_control.sv ====
// Control and mode logic of a dual-channel converter with an AHB-Lite register slave.
// Behaviour
// R1: Input below negative full scale gives an all-zero output word.
// R2: Input above positive full scale gives an all-one output word.
// R3: Either range fault raises that channel's out-of-range output.
// R4: Serial mode gives each channel 15-bit gain and 12-bit-plus-sign offset.
// R5: Demux halves each bus rate; otherwise one bus per channel at sample rate.
// R6: Mode pin high: pin control, register writes ignored, pins rule.
// R7: Dual-edge pin high selects interleaved sampling, low independent channels.
// R8: Interleaved: one converter takes rising edge, the other falling edge.
// R9: Pin mode interleaves I input only; serial bits pick Q or both.
// R10: Serial mode takes interleave enable from configuration bit 7.
// R11: Demux pin low gives demultiplexed output, high non-demultiplexed.
// R12: Buses used: one or two per channel, two or four when interleaved.
// R13: Double data rate without demux, single data rate with demux.
// R14: Demux selection comes from its pin in both control modes.
// R15: Phase pin picks 0/90 degrees in DDR, falling/rising in SDR.
// R16: 0 degrees moves data with clock edges, 90 degrees between edges.
// R17: Serial mode takes output phase from configuration bit 14.
// R18: Controller holds calibration pin low, then high, each a minimum time.
// R19: Calibration pin high at power-on skips power-on calibration.
// R20: Serial mode ORs calibration pin with configuration bit 15.
// R21: Wait pin picks short or long power-on calibration delay, both modes.
// R22: Controller sets the wait pin before power-on and leaves it.
// R23: Mode pin low selects serial mode; returning high resets registers.
// R24: Powered-down channel floats its data outputs.
// R25: Pattern pin replaces converter data and range flags with a pattern.
// R26: Calibration request is synchronised and qualified by low/high counts.
// R27: Mode pins apply synchronously at word-pair boundaries without glitches.
module acm_control
  import acm_pkg::*;
#(
  parameter logic [23:0] WAIT_SHORT = 24'd65536,
  parameter logic [23:0] WAIT_LONG  = 24'd1048576,
  parameter logic [23:0] CAL_RUN    = 24'd8192
)
(
  // Clock and reset.
  input  wire logic            clk,
  input  wire logic            rst,
  // AHB-Lite slave.
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic      [31:0]     hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  // Static control pins.
  input  wire logic            extended_ctrl_select_n,
  input  wire logic            desPin,
  input  wire logic            no_demux_sel,
  input  wire logic            output_phase_sel,
  input  wire logic            calPin,
  input  wire logic            selftrim_wait_sel,
  input  wire logic            power_down_i_chan,
  input  wire logic            power_down_q_chan,
  input  wire logic            pattern_output_sel,
  // Converter results (index 0 rising-edge I, 1 falling-edge Q).
  input  wire acm_conv_t [1:0] convIn,
  // Output buses: 0 i_bus_primary, 1 i_bus_delayed, 2 q_bus_primary, 3 q_bus_delayed.
  output logic [3:0][11:0]     busData,
  output logic [3:0]           busOe,
  output logic                 i_output_clock,
  output logic                 q_output_clock,
  output logic                 overrange_i_flag,
  output logic                 overrange_q_flag,
  // Analog steering and calibration status.
  output acm_insel_t           desInputSel,
  output logic                 calRunning
);
  // ****************************************
  // Pin synchronisation
  // ****************************************
  logic [PIN_N-1:0] pinS;
  acm_sync #(.W(PIN_N)) uSync
  (
    .clk    (clk),
    .rst    (rst),
    .pinIn  ({pattern_output_sel, power_down_q_chan, power_down_i_chan, selftrim_wait_sel,
              calPin, output_phase_sel, no_demux_sel, desPin, extended_ctrl_select_n}),
    .pinOut (pinS)
  );

  logic        serialMode;
  logic [15:0] cfg_r;
  logic [14:0] gain_r [2];
  logic [12:0] ofs_r  [2];
  acm_mode_t   mode_r;
  acm_mode_t   mode_nxt;
  logic        pair_r;
  typedef enum {CAL_WAIT, CAL_IDLE, CAL_BUSY} acm_cal_t;
  acm_cal_t    calSt_r;
  logic [23:0] calCnt_r;
  logic        modeOk;

  assign serialMode = !pinS[P_MODE_N]; // see R6 see R23

  // ****************************************
  // AHB-Lite register slave
  // ****************************************
  logic       wrPend_r;
  logic [7:0] wrAddr_r;
  logic       take;
  logic [31:0] rdVal;

  assign take      = hsel && hready && htrans == HTRANS_NONSEQ;
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

  // Read mux; unmapped offsets read zero.
  always_comb
  begin
    rdVal = '0;
    case (haddr[7:0])
      REG_CFG:    rdVal[15:0] = cfg_r;
      REG_GAIN_I: rdVal[14:0] = gain_r[0];
      REG_GAIN_Q: rdVal[14:0] = gain_r[1];
      REG_OFS_I:  rdVal[12:0] = ofs_r[0];
      REG_OFS_Q:  rdVal[12:0] = ofs_r[1];
      REG_STATUS: rdVal[7:0]  = {calRunning, mode_r.serial, mode_r.des, mode_r.demux,
                                 mode_r.phase, mode_r.pattern, overrange_q_flag,
                                 overrange_i_flag};
      default:    rdVal = '0;
    endcase
  end

  // Address phase capture; read data is registered for the following data phase.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wrPend_r <= 1'b0;
      wrAddr_r <= '0;
      hrdata   <= '0;
    end
    else
    begin
      wrPend_r <= take && hwrite;
      wrAddr_r <= haddr[7:0];
      if (take && !hwrite)
        hrdata <= rdVal;
    end
  end

  // Writes land only in serial mode; pin mode holds every register at default.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_r  <= CFG_RST;
      gain_r <= '{GAIN_RST, GAIN_RST};
      ofs_r  <= '{OFS_RST, OFS_RST};
    end
    else if (!serialMode)
    begin
      cfg_r  <= CFG_RST; // see R23
      gain_r <= '{GAIN_RST, GAIN_RST};
      ofs_r  <= '{OFS_RST, OFS_RST};
    end
    else if (wrPend_r)
    begin
      case (wrAddr_r)
        REG_CFG:    cfg_r    <= hwdata[15:0]; // see R10 see R17
        REG_GAIN_I: gain_r[0] <= hwdata[GAIN_W-1:0]; // see R4
        REG_GAIN_Q: gain_r[1] <= hwdata[GAIN_W-1:0];
        REG_OFS_I:  ofs_r[0] <= hwdata[OFS_W-1:0];
        REG_OFS_Q:  ofs_r[1] <= hwdata[OFS_W-1:0];
        default:    cfg_r    <= cfg_r;
      endcase
    end
  end

  // ****************************************
  // Mode selection
  // ****************************************
  always_comb
  begin
    mode_nxt.serial  = serialMode;
    mode_nxt.des     = serialMode ? cfg_r[CFG_DES] : pinS[P_DES]; // see R7 see R10
    mode_nxt.demux   = !pinS[P_NODEMUX]; // see R11 see R14
    mode_nxt.phase   = serialMode ? cfg_r[CFG_PHASE] : pinS[P_PHASE]; // see R15 see R17
    mode_nxt.pattern = pinS[P_PATTERN];
    if (serialMode && cfg_r[CFG_BOTH])
      mode_nxt.inSel = SEL_BOTH; // see R9
    else if (serialMode && cfg_r[CFG_DEQ])
      mode_nxt.inSel = SEL_Q;
    else
      mode_nxt.inSel = SEL_I;
  end

  // The synchroniser reads low until it has filled, so the reset mode is kept until then.
  assign modeOk = calSt_r != CAL_WAIT || calCnt_r > STRAP_CYC;

  // Mode changes wait for a pair boundary so no half-written pair leaves.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mode_r <= '{serial: 1'b0, des: 1'b0, demux: 1'b0, phase: 1'b0, pattern: 1'b0,
                 inSel: SEL_I};
    else if (!pair_r && modeOk)
      mode_r <= mode_nxt; // see R27
  end

  assign desInputSel = mode_r.inSel; // see R9

  // ****************************************
  // Gain, offset and range handling
  // ****************************************
  // Gain is unsigned with unity at 2^14; offset is sign-magnitude.
  function automatic logic [11:0] adjust(input logic [11:0] code, input logic [14:0] gain,
                                         input logic [12:0] ofs);
    logic [26:0] prod;
    logic [14:0] sum;
    prod = code * gain;
    sum  = {2'b00, prod[GAIN_SH+12:GAIN_SH]};
    if (ofs[OFS_SIGN])
      sum = sum - {3'b000, ofs[11:0]};
    else
      sum = sum + {3'b000, ofs[11:0]};
    if (sum[14])
      adjust = CODE_MIN;
    else if (sum[13:12] != 2'b00)
      adjust = CODE_MAX;
    else
      adjust = sum[11:0];
  endfunction

  logic [11:0] tpCnt_r;
  logic [11:0] word_r [2];
  logic [1:0]  flag_r;

  // Pattern counter runs freely so the capture side sees a moving ramp.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tpCnt_r <= '0;
    else
      tpCnt_r <= tpCnt_r + 12'h001;
  end

  // In interleave mode converter 0 holds the rising-edge sample, 1 the falling one.
  for (genvar c = 0; c < 2; c++)
  begin : gConv
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        word_r[c] <= '0;
        flag_r[c] <= 1'b0;
      end
      else if (mode_r.pattern)
      begin
        word_r[c] <= c ? ~tpCnt_r : tpCnt_r; // see R25
        flag_r[c] <= tpCnt_r[0];
      end
      else if (convIn[c].under)
      begin
        word_r[c] <= CODE_MIN; // see R1
        flag_r[c] <= 1'b1; // see R3
      end
      else if (convIn[c].over)
      begin
        word_r[c] <= CODE_MAX; // see R2
        flag_r[c] <= 1'b1;
      end
      else
      begin
        word_r[c] <= mode_r.serial ? adjust(convIn[c].code, gain_r[c], ofs_r[c])
                                   : convIn[c].code; // see R4 see R8
        flag_r[c] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Output buses
  // ****************************************
  logic [11:0] hold_r [2];
  logic [1:0]  pdS;
  assign pdS = {pinS[P_PD_Q], pinS[P_PD_I]};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pair_r <= 1'b0;
    else
      pair_r <= !pair_r;
  end

  // Demux: older word goes to the delayed bus, newer to primary, every other cycle.
  for (genvar c = 0; c < 2; c++)
  begin : gBus
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        hold_r[c]      <= '0;
        busData[2*c]   <= '0;
        busData[2*c+1] <= '0;
        busOe[2*c]     <= 1'b0;
        busOe[2*c+1]   <= 1'b0;
      end
      else
      begin
        busOe[2*c]   <= !pdS[c]; // see R24 see R12
        busOe[2*c+1] <= mode_r.demux && !pdS[c]; // see R5 see R12
        // Holding in every mode keeps the first pair after a switch to demux whole.
        if (!pair_r)
          hold_r[c] <= word_r[c];
        if (!mode_r.demux)
          busData[2*c] <= word_r[c]; // see R5
        else if (pair_r)
        begin
          busData[2*c]   <= word_r[c];
          busData[2*c+1] <= hold_r[c];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      overrange_i_flag <= 1'b0;
      overrange_q_flag <= 1'b0;
    end
    else
    begin
      overrange_i_flag <= flag_r[0]; // see R3
      overrange_q_flag <= flag_r[1];
    end
  end

  // ****************************************
  // Output clock
  // ****************************************
  logic ckPos_r;
  logic ckNeg_r;
  logic ckOut;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ckPos_r <= 1'b0;
    else
      ckPos_r <= !ckPos_r;
  end

  // Falling-edge copy moves clock edges half a sample between data changes.
  always_ff @(negedge clk or posedge rst)
  begin
    if (rst)
      ckNeg_r <= 1'b0;
    else
      ckNeg_r <= ckPos_r;
  end

  // DDR without demux, SDR with demux; the same clock serves both channels.
  always_comb
  begin
    if (!mode_r.demux)
      ckOut = mode_r.phase ? ckNeg_r : ckPos_r; // see R13 see R15 see R16
    else
      ckOut = mode_r.phase ? pair_r : !pair_r; // see R13 see R15
  end
  assign i_output_clock = ckOut; // see R16
  assign q_output_clock = ckOut;

  // ****************************************
  // Calibration
  // ****************************************
  logic [15:0] lowCnt_r;
  logic [15:0] highCnt_r;
  logic        lowOk_r;
  logic        skip_r;
  logic        long_r;
  logic        calReq;
  logic        calStart;

  assign calReq   = pinS[P_CAL] | (serialMode & cfg_r[CFG_CAL]); // see R20
  assign calStart = lowOk_r && calReq && highCnt_r == CAL_HIGH_MIN - 16'd1; // see R26

  // Low then high qualification; a short high pulse is dropped.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lowCnt_r  <= '0;
      highCnt_r <= '0;
      lowOk_r   <= 1'b0;
    end
    else if (!calReq)
    begin
      highCnt_r <= '0;
      lowOk_r   <= lowCnt_r >= CAL_LOW_MIN - 16'd1; // see R18 see R26
      if (lowCnt_r != CAL_LOW_MIN)
        lowCnt_r <= lowCnt_r + 16'd1;
    end
    else
    begin
      lowCnt_r  <= '0;
      highCnt_r <= calStart ? '0 : highCnt_r + 16'd1;
      if (calStart)
        lowOk_r <= 1'b0;
    end
  end

  // Straps are caught once the synchroniser has settled after reset release.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      calSt_r <= CAL_WAIT;
      calCnt_r <= '0;
      skip_r  <= 1'b0;
      long_r  <= 1'b0;
    end
    else
    begin
      calCnt_r <= calCnt_r + 24'd1;
      if (calSt_r == CAL_WAIT && calCnt_r == STRAP_CYC)
      begin
        skip_r <= pinS[P_CAL]; // see R19
        long_r <= pinS[P_WAIT]; // see R21 see R22
      end
      case (calSt_r)
        CAL_WAIT:
          if (calCnt_r > STRAP_CYC && calCnt_r >= (long_r ? WAIT_LONG : WAIT_SHORT))
          begin
            calSt_r  <= skip_r ? CAL_IDLE : CAL_BUSY; // see R19 see R21
            calCnt_r <= '0;
          end
        CAL_IDLE:
          if (calStart)
          begin
            calSt_r  <= CAL_BUSY;
            calCnt_r <= '0;
          end
        CAL_BUSY:
          if (calCnt_r == CAL_RUN - 24'd1)
            calSt_r <= CAL_IDLE;
        default:
          calSt_r <= CAL_IDLE;
      endcase
    end
  end

  assign calRunning = calSt_r == CAL_BUSY;

  // ****************************************
  // Assertions
  // ****************************************
  a_under_zero: assert property (@(posedge clk) disable iff (rst) // see R1
    !mode_r.pattern && convIn[0].under |=> word_r[0] == CODE_MIN ##1 overrange_i_flag)
    else $error("Under-range word is not all zero.");
  a_over_ones: assert property (@(posedge clk) disable iff (rst) // see R2
    !mode_r.pattern && !convIn[1].under && convIn[1].over |=> word_r[1] == CODE_MAX)
    else $error("Over-range word is not all ones.");
  a_range_flag: assert property (@(posedge clk) disable iff (rst) // see R3
    !mode_r.pattern && (convIn[1].under || convIn[1].over) |-> ##2 overrange_q_flag)
    else $error("Range flag missing on Q channel.");
  a_pd_float: assert property (@(posedge clk) disable iff (rst) // see R24
    pdS[0] |=> !busOe[0] && !busOe[1])
    else $error("Powered-down I channel still drives.");
  a_demux_bus: assert property (@(posedge clk) disable iff (rst) // see R12
    !pdS[1] && $stable(pdS[1]) |=> busOe[3] == $past(mode_r.demux))
    else $error("Delayed Q bus enable wrong for demux mode.");
  a_ddr_clock: assert property (@(posedge clk) disable iff (rst) // see R13
    !mode_r.demux && !mode_r.phase && $stable(mode_r) && !$past(rst)
      |-> i_output_clock != $past(i_output_clock))
    else $error("DDR output clock did not toggle.");
  a_pin_regs: assert property (@(posedge clk) disable iff (rst) // see R23
    !serialMode |=> cfg_r == CFG_RST && gain_r[0] == GAIN_RST)
    else $error("Registers not at default in pin mode.");
  a_cal_start: assert property (@(posedge clk) disable iff (rst) // see R26
    calSt_r == CAL_IDLE && calStart |=> calRunning)
    else $error("Qualified request did not start calibration.");
  a_pin_interleave_i_input: assert property (@(posedge clk) disable iff (rst) // see R9
    !mode_r.serial |-> desInputSel == SEL_I)
    else $error("Pin mode interleaves other than I input.");
  a_pattern: assert property (@(posedge clk) disable iff (rst) // see R25
    mode_r.pattern |=> word_r[0] == $past(tpCnt_r))
    else $error("Pattern not driven on I path.");
endmodule // acm_control

// ==== testbench/acm_far_model.sv ====
// Far-side model: converter result source and board calibration driver.
module acm_far_model
  import acm_pkg::*;
(
  // Clock.
  input  wire logic       clk,
  // Bench commands.
  input  wire logic       ramp,
  input  wire logic       under,
  input  wire logic       over,
  input  wire logic       calGo,
  // Toward the block.
  output acm_conv_t [1:0] convIn,
  output logic            calPin
);
  // ****************************************
  // Converter results and calibration pin
  // ****************************************
  logic [11:0] cnt_r    = 12'h000;
  logic [15:0] calCnt_r = 16'h0000;
  logic        calOn_r  = 1'b0;

  // A ramping code makes the order of samples on the buses visible.
  always_ff @(posedge clk)
  begin
    cnt_r <= ramp ? cnt_r + 12'h001 : 12'h5a3;
  end
  assign convIn[0] = {cnt_r, under, over};
  assign convIn[1] = {~cnt_r, 1'b0, 1'b0};

  // The pin is held low one cycle past the minimum, then high until the next request.
  always_ff @(posedge clk)
  begin
    if (calGo)
    begin
      calOn_r  <= 1'b1;
      calCnt_r <= 16'h0000;
    end
    else if (calOn_r && calCnt_r != 16'hffff)
      calCnt_r <= calCnt_r + 16'h0001;
  end
  assign calPin = calOn_r && (calCnt_r > CAL_LOW_MIN);
endmodule  // acm_far_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the converter control block.
module tb_top
  import acm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] RUN = 24'd16;
  logic                clk, rst, hsel, hwrite, hready, hreadyout, hresp, ramp, under, over;
  logic                extended_ctrl_select_n, desPin, no_demux_sel, output_phase_sel, calPin;
  logic                selftrim_wait_sel, power_down_i_chan, power_down_q_chan, calGo;
  logic                pattern_output_sel, i_output_clock, q_output_clock, calRunning;
  logic                overrange_i_flag, overrange_q_flag;
  logic [31:0]         haddr, hwdata, hrdata, rd;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic [3:0][11:0]    busData;
  logic [3:0]          busOe;
  acm_conv_t [1:0]     convIn;
  acm_insel_t          desInputSel;
  int                  n_mismatch = 0;
  int                  n_compared = 0;
  int                  n;

  // The single slave's ready is the bus ready.
  assign hready = hreadyout;

  acm_control #(.WAIT_SHORT(24'd32), .WAIT_LONG(24'd64), .CAL_RUN(RUN)) acm_control_inst (
    .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .extended_ctrl_select_n, .desPin, .no_demux_sel, .output_phase_sel,
    .calPin, .selftrim_wait_sel, .power_down_i_chan, .power_down_q_chan, .pattern_output_sel,
    .convIn, .busData, .busOe, .i_output_clock, .q_output_clock, .overrange_i_flag,
    .overrange_q_flag, .desInputSel, .calRunning);

  acm_far_model acm_far_model_inst (.clk, .ramp, .under, .over, .calGo, .convIn, .calPin);

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Pins pass a three-flop filter and a pair boundary, so give them time to land.
  task automatic settle;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic waitCal(input logic lvl, output int k);
    for (k = 0; k < 3000 && calRunning !== lvl; k++) @(negedge clk);
  endtask

  task automatic print_verdict;
    $display("mismatches %0d of %0d compared", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_power;
    waitCal(1'b1, n);
    chk(calRunning, 1'b1);
    waitCal(1'b0, n);
    chk(n, RUN);
  endtask

  task automatic t_range;
    @(posedge clk);
    under <= 1'b1;
    settle;
    chk(busData[0], CODE_MIN);
    chk({overrange_q_flag, overrange_i_flag}, 2'b01);
    chk(busOe, 4'b0101);
    @(posedge clk);
    under <= 1'b0;
    over <= 1'b1;
    settle;
    chk(busData[0], CODE_MAX);
    chk(overrange_i_flag, 1'b1);
    @(posedge clk);
    over <= 1'b0;
    settle;
    chk(busData[0], 12'h5a3);
    chk(q_output_clock, i_output_clock);
    n = i_output_clock;
    @(negedge clk);
    chk(i_output_clock, !n[0]);
  endtask

  task automatic t_demux;
    logic [11:0] v;
    @(posedge clk);
    ramp <= 1'b1;
    no_demux_sel <= 1'b0;
    settle;
    v = busData[0];
    chk(busOe, 4'hf);
    chk(busData[0], busData[1] + 12'h001);
    chk(busData[2], 12'(~busData[0]));
    repeat (2) @(negedge clk);
    chk(busData[0], v + 12'h002);
    @(posedge clk);
    ramp <= 1'b0;
    no_demux_sel <= 1'b1;
  endtask

  task automatic t_regs;
    ahb(1'b1, REG_CFG, 32'h80);
    ahb(1'b0, REG_CFG, 32'h0);
    chk(rd, 32'h0);
    chk(hresp, HRESP_OKAY);
    @(posedge clk);
    extended_ctrl_select_n <= 1'b0;
    no_demux_sel <= 1'b0;
    settle;
    chk(busOe, 4'hf);
    ahb(1'b1, REG_CFG, 32'hc0);
    ahb(1'b0, REG_CFG, 32'h0);
    chk(rd, 32'hc0);
    settle;
    chk(desInputSel, SEL_Q);
    ahb(1'b0, REG_GAIN_I, 32'h0);
    chk(rd, GAIN_RST);
    ahb(1'b1, REG_GAIN_Q, 32'hffffffff);
    ahb(1'b0, REG_GAIN_Q, 32'h0);
    chk(rd, 32'h7fff);
    ahb(1'b1, REG_OFS_Q, 32'hffffffff);
    ahb(1'b0, REG_OFS_Q, 32'h0);
    chk(rd, 32'h1fff);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    repeat (CAL_LOW_MIN) @(posedge clk);
    ahb(1'b1, REG_CFG, 32'h8000);
    waitCal(1'b1, n);
    chk(calRunning, 1'b1);
    waitCal(1'b0, n);
    @(posedge clk);
    extended_ctrl_select_n <= 1'b1;
    no_demux_sel <= 1'b1;
    desPin <= 1'b1;
    settle;
    chk(desInputSel, SEL_I);
    @(posedge clk);
    extended_ctrl_select_n <= 1'b0;
    settle;
    ahb(1'b0, REG_CFG, 32'h0);
    chk(rd, 32'h0);
    @(posedge clk);
    extended_ctrl_select_n <= 1'b1;
    desPin <= 1'b0;
  endtask

  task automatic t_float;
    @(posedge clk);
    power_down_i_chan <= 1'b1;
    settle;
    chk(busOe, 4'b0100);
    @(posedge clk);
    power_down_i_chan <= 1'b0;
    power_down_q_chan <= 1'b1;
    settle;
    chk(busOe, 4'b0001);
    @(posedge clk);
    power_down_q_chan <= 1'b0;
    pattern_output_sel <= 1'b1;
    settle;
    chk(busData[2], 12'(~busData[0]));
    @(posedge clk);
    pattern_output_sel <= 1'b0;
  endtask

  // The request must not start before the high phase has been qualified.
  task automatic t_cal;
    @(posedge clk);
    calGo <= 1'b1;
    @(posedge clk);
    calGo <= 1'b0;
    wait (calPin === 1'b1);
    @(negedge clk);
    chk(calRunning, 1'b0);
    waitCal(1'b1, n);
    chk(n >= 1279 && n <= 1295, 1'b1);
    waitCal(1'b0, n);
    chk(n, RUN);
  endtask

  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The tests take under ten thousand cycles; twice that means a hang.
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata, desPin, output_phase_sel, calGo} = '0;
    {selftrim_wait_sel, power_down_i_chan, power_down_q_chan, pattern_output_sel} = '0;
    {ramp, under, over} = '0;
    hsize = 3'b010;
    extended_ctrl_select_n = 1'b1;
    no_demux_sel = 1'b1;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_power();
    t_range();
    t_demux();
    t_regs();
    t_float();
    t_cal();
    print_verdict();
  end
endmodule  // tb_top
